// File: bench/jmsf_bench.sv
// self-checking bench for the mode and status flag register bank
`timescale 1ns/1ps
`default_nettype none
module jmsf_bench;
    import jmsf_pkg::*;
    logic ref_clk_in, sys_rst_in, en, rd_s, wr_s, wreq, file_out, ddone, derr, mark;
    logic lbovf, cirq, opr, lbp, mclk, mrst, byp, yin, yout, y420, hc, noofs, rot, irq;
    logic [11:0] adr;
    logic [15:0] wd, rdat, fcnt, fsize, seed, v, c;
    logic [1:0] be, tsel, emode, resp;
    logic [2:0] dmode;
    logic [31:0] lim, res;
    int n_fail, n_checks, n_rst;
    int cs[8] = '{0, 4, 5, 16, 17, 32, 33, 64};

    jmsf_top i_jmsf_top (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(en),
        .avs_address_in(adr), .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .avs_response_out(resp), .codec_file_out_in(file_out), .fifo_count_in(fcnt),
        .fifo_size_in(fsize), .fifo_trig_sel_in(tsel), .enc_size_limit_in(lim),
        .enc_size_result_in(res), .decode_done_in(ddone), .decode_err_in(derr),
        .err_det_mode_in(emode), .marker_read_in(mark), .lb_overflow_in(lbovf),
        .codec_irq_in(cirq), .op_status_read_in(opr), .lb_req_pending_in(lbp),
        .module_clk_en_out(mclk), .module_rst_out(mrst), .data_mode_out(dmode),
        .bypass_out(byp), .host_yuv_in_out(yin), .host_yuv_out_out(yout), .yuv420_out(y420),
        .host_codec_out(hc), .no_offset_out(noofs), .rotate_out(rot), .irq_out(irq));
    jmsf_host i_jmsf_host (.ref_clk_in(ref_clk_in), .avs_address_out(adr),
        .avs_read_out(rd_s), .avs_write_out(wr_s), .avs_writedata_out(wd),
        .avs_byteenable_out(be), .avs_readdata_in(rdat), .avs_waitrequest_in(wreq));

    // free-running 250 MHz clock
    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    // count module reset pulses seen at the port
    always @(posedge ref_clk_in) if (mrst === 1'b1) n_rst++;

    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx
    // expected status word from raw flags, enables and live fifo level
    function automatic logic [15:0] st(input logic [15:0] raw, input logic [15:0] ien);
        logic [1:0] l;
        l = (fcnt > (fsize >> 1)) ? 2'b11 : (fcnt > (fsize >> 2)) ? 2'b10 :
            (fcnt > JMSF_LVL_SMALL) ? 2'b01 : 2'b00;
        return JMSF_STAT_FIXED | {1'b0, file_out, l, 12'h000} | (raw & ien & JMSF_IEN_WMASK);
    endfunction : st
    // expected fifo flags: threshold, full, empty
    function automatic logic [15:0] fr(input logic [15:0] k, input logic [1:0] t);
        logic th;
        th = (t == 2'b00) ? (k != 0) : (t == 2'b01) ? (k > JMSF_LVL_SMALL) :
             (t == 2'b10) ? (k > (fsize >> 2)) : (k > (fsize >> 1));
        return {5'h00, th, (k >= fsize) && (fsize != 0), k == 0, 8'h00};
    endfunction : fr
    // expected routing outputs for a control value
    function automatic logic [15:0] md(input logic [15:0] w);
        logic [2:0] m;
        m = w[3:1];
        return {4'h0, m, m[0], m == 3'b001 || m == 3'b101, m == 3'b011 || m == 3'b111,
                m == 3'b101 || m == 3'b111, m == 3'b100, w[4], w[8], w[0]};
    endfunction : md

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    // one bus access with a random idle gap; a hung slave ends the run
    task automatic acc(input logic rw, input logic [11:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        logic ok;
        seed = nx(seed);
        i_jmsf_host.xfer(rw, a, d, seed % 3, q, ok);
        if (ok !== 1'b1) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : acc
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [15:0] q;
        acc(1'b1, a, d, q);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [15:0] exp);
        logic [15:0] q;
        acc(1'b0, a, 16'h0000, q);
        chk(q, exp);
    endtask : rdc
    // park the fifo where no fifo flag holds, then clear stale ones
    task automatic neutral();
        fcnt <= 16'h0005;
        tsel <= 2'b10;
        wr(JMSF_STAT_ADDR, 16'h0F00);
    endtask : neutral

    // main sequence
    initial begin
        {n_fail, n_checks, n_rst} = 0;
        seed = 16'h0039;
        {en, sys_rst_in} = 2'b11;
        {file_out, ddone, derr, mark, lbovf, cirq, opr, lbp, tsel, emode} = 0;
        {fcnt, fsize, lim, res} = {16'h0000, 16'h0040, 32'h0000_0100, 32'h0000_0000};
        repeat (4) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        rdc(JMSF_CTRL_ADDR, JMSF_CTRL_RST);
        rdc(JMSF_IEN_ADDR, JMSF_IEN_RST);
        rdc(JMSF_STAT_ADDR, st(16'h0100, 16'h0000));
        rdc(12'h9A0, 16'h0000);
        chk({14'h0000, resp}, 16'h0000);
        for (int m = 0; m < 8; m++) begin
            seed = nx(seed);
            v = {7'h00, seed[8], 3'b000, seed[4], m[2:0], 1'b1};
            wr(JMSF_CTRL_ADDR, v);
            rdc(JMSF_CTRL_ADDR, v & JMSF_CTRL_WMASK);
            chk({dmode, byp, yin, yout, y420, hc, noofs, rot, mclk}, md(v));
        end
        wr(JMSF_CTRL_ADDR, 16'h0000);
        chk({15'h0000, mclk}, 16'h0000);
        wr(JMSF_IEN_ADDR, 16'hFFFF);
        rdc(JMSF_IEN_ADDR, JMSF_IEN_WMASK);
        for (int i = 0; i < 16; i++) begin
            seed = nx(seed);
            c = (i < 8) ? 16'(cs[i]) : 16'(seed % 80);
            fcnt <= c;
            tsel <= (i < 8) ? i[1:0] : seed[6:5];
            file_out <= seed[0];
            wr(JMSF_STAT_ADDR, 16'h0F00);
            rdc(JMSF_STAT_ADDR, st(fr(c, tsel), 16'hFFFF));
            chk({15'h0000, irq}, {15'h0000, |fr(c, tsel)});
        end
        neutral();
        {lim, res} <= {32'h0000_0100, 32'h0000_0101};
        wr(JMSF_STAT_ADDR, 16'h0800);
        rdc(JMSF_STAT_ADDR, st(16'h0800, 16'hFFFF));
        lim <= 32'h0000_0102;
        rdc(JMSF_STAT_ADDR, st(16'h0800, 16'hFFFF));
        wr(JMSF_STAT_ADDR, 16'h0800);
        rdc(JMSF_STAT_ADDR, st(16'h0000, 16'hFFFF));
        {emode, derr, ddone} <= {JMSF_ERRDET_ON, 2'b11};
        @(posedge ref_clk_in);
        {emode, derr, ddone} <= {2'b00, 2'b10};
        rdc(JMSF_STAT_ADDR, st(16'h0000, 16'hFFFF));
        ddone <= 1'b1;
        @(posedge ref_clk_in);
        {derr, ddone} <= 2'b00;
        rdc(JMSF_STAT_ADDR, st(16'h0020, 16'hFFFF));
        wr(JMSF_STAT_ADDR, 16'h0000);
        rdc(JMSF_STAT_ADDR, st(16'h0020, 16'hFFFF));
        wr(JMSF_STAT_ADDR, 16'h0020);
        rdc(JMSF_STAT_ADDR, st(16'h0000, 16'hFFFF));
        mark <= 1'b1;
        @(posedge ref_clk_in);
        mark <= 1'b0;
        rdc(JMSF_STAT_ADDR, st(16'h0010, 16'hFFFF));
        wr(JMSF_IEN_ADDR, 16'h0F27);
        wr(JMSF_IEN_ADDR, 16'h0F37);
        rdc(JMSF_STAT_ADDR, st(16'h0000, 16'hFFFF));
        wr(JMSF_IEN_ADDR, 16'h0000);
        lbovf <= 1'b1;
        @(posedge ref_clk_in);
        lbovf <= 1'b0;
        rdc(JMSF_STAT_ADDR, st(16'h0004, 16'h0000));
        chk({15'h0000, irq}, 16'h0000);
        wr(JMSF_IEN_ADDR, 16'h0F37);
        wr(JMSF_STAT_ADDR, 16'h0004);
        rdc(JMSF_STAT_ADDR, st(16'h0004, 16'hFFFF));
        chk({15'h0000, irq}, 16'h0001);
        wr(JMSF_CTRL_ADDR, 16'h0000);
        chk(16'(n_rst), 16'h0000);
        wr(JMSF_CTRL_ADDR, 16'h0080);
        rdc(JMSF_STAT_ADDR, st(16'h0000, 16'hFFFF));
        chk(16'(n_rst), 16'h0001);
        cirq <= 1'b1;
        @(posedge ref_clk_in);
        cirq <= 1'b0;
        rdc(JMSF_STAT_ADDR, st(16'h0002, 16'hFFFF));
        opr <= 1'b1;
        @(posedge ref_clk_in);
        opr <= 1'b0;
        rdc(JMSF_STAT_ADDR, st(16'h0000, 16'hFFFF));
        wr(JMSF_CTRL_ADDR, 16'h0001);
        lbp <= 1'b1;
        rdc(JMSF_STAT_ADDR, st(16'h0000, 16'hFFFF));
        wr(JMSF_CTRL_ADDR, 16'h0003);
        rdc(JMSF_STAT_ADDR, st(16'h0001, 16'hFFFF));
        lbp <= 1'b0;
        rdc(JMSF_STAT_ADDR, st(16'h0000, 16'hFFFF));
        // a codec interrupt pulse while the clock enable is low must be lost
        en <= 1'b0;
        cirq <= 1'b1;
        @(posedge ref_clk_in);
        cirq <= 1'b0;
        @(posedge ref_clk_in);
        en <= 1'b1;
        rdc(JMSF_STAT_ADDR, st(16'h0000, 16'hFFFF));
        tally_and_finish();
    end
endmodule : jmsf_bench
`default_nettype wire

// File: bench/jmsf_host.sv
// host processor model: avalon-mm master that reaches the register bank
`timescale 1ns/1ps
`default_nettype none
module jmsf_host (
    // clock
    input wire logic ref_clk_in,
    // avalon-mm master side
    output logic [11:0] avs_address_out,
    output logic avs_read_out,
    output logic avs_write_out,
    output logic [15:0] avs_writedata_out,
    output logic [1:0] avs_byteenable_out,
    input wire logic [15:0] avs_readdata_in,
    input wire logic avs_waitrequest_in
);
    // idle bus; no read or write, both byte enables set
    initial begin
        avs_address_out = 12'h000;
        avs_read_out = 1'b0;
        avs_write_out = 1'b0;
        avs_writedata_out = 16'h0000;
        avs_byteenable_out = 2'b11;
    end

    // one access after gap idle cycles, so prompt and slow hosts both occur
    task automatic xfer(input logic rw, input logic [11:0] a, input logic [15:0] wd,
                        input int gap, output logic [15:0] rd, output logic ok);
        ok = 1'b0;
        rd = 16'h0000;
        repeat (gap) @(posedge ref_clk_in);
        @(posedge ref_clk_in);
        avs_address_out <= a;
        avs_read_out <= !rw;
        avs_write_out <= rw;
        avs_writedata_out <= wd;
        for (int i = 0; i < 16 && !ok; i++) begin
            @(posedge ref_clk_in);
            if (avs_waitrequest_in === 1'b0) begin
                rd = avs_readdata_in;
                ok = 1'b1;
            end
        end
        avs_read_out <= 1'b0;
        avs_write_out <= 1'b0;
        avs_writedata_out <= ~wd;  // released data must not linger
        avs_address_out <= ~a;
    endtask : xfer
endmodule : jmsf_host
`default_nettype wire

// File: logic/jmsf_pkg.sv
// constants and types for the compression module mode and status flag block
package jmsf_pkg;
    // byte addresses on the register bus
    localparam logic [11:0] JMSF_CTRL_ADDR = 12'h0980;
    localparam logic [11:0] JMSF_STAT_ADDR = 12'h0982;
    localparam logic [11:0] JMSF_IEN_ADDR = 12'h0986;
    // control field positions
    localparam int JMSF_EN_BIT = 0;
    localparam int JMSF_MODE_LSB = 1;
    localparam int JMSF_NOOFS_BIT = 4;
    localparam int JMSF_ROT_BIT = 8;
    localparam int JMSF_SWRST_BIT = 7;
    // status bit positions
    localparam int JMSF_ST_FILEOUT = 14;
    localparam int JMSF_ST_LVL_LSB = 12;
    localparam int JMSF_ST_SIZE = 11;
    localparam int JMSF_ST_THR = 10;
    localparam int JMSF_ST_FULL = 9;
    localparam int JMSF_ST_EMPTY = 8;
    localparam int JMSF_ST_DEC = 5;
    localparam int JMSF_ST_MARK = 4;
    localparam int JMSF_ST_LBOVF = 2;
    localparam int JMSF_ST_CODEC = 1;
    localparam int JMSF_ST_LBINT = 0;
    // writable masks and reset values
    localparam logic [15:0] JMSF_CTRL_WMASK = 16'h011F;
    localparam logic [15:0] JMSF_IEN_WMASK = 16'h0F37;
    localparam logic [15:0] JMSF_W1C_MASK = 16'h0F20;
    localparam logic [15:0] JMSF_CTRL_RST = 16'h0000;
    localparam logic [15:0] JMSF_IEN_RST = 16'h0000;
    localparam logic [15:0] JMSF_STAT_FIXED = 16'h0080;
    // fifo level threshold, error detect on value and normal mode
    localparam logic [15:0] JMSF_LVL_SMALL = 16'h0004;
    localparam logic [1:0] JMSF_ERRDET_ON = 2'b01;
    localparam logic [2:0] JMSF_MODE_NORMAL = 3'b000;
    // data path modes
    typedef enum logic [2:0] {
        JMSF_M_NORMAL = 3'b000,
        JMSF_M_YUV422_IN = 3'b001,
        JMSF_M_RSVD2 = 3'b010,
        JMSF_M_YUV422_OUT = 3'b011,
        JMSF_M_HOST_CODEC = 3'b100,
        JMSF_M_YUV420_IN = 3'b101,
        JMSF_M_RSVD6 = 3'b110,
        JMSF_M_YUV420_OUT = 3'b111
    } jmsf_mode_e;
    // bus handshake state
    typedef enum logic [1:0] {
        JMSF_BS_IDLE,
        JMSF_BS_ACK
    } jmsf_bus_e;
endpackage : jmsf_pkg

// File: logic/jmsf_top.sv
// compression module control, mode routing and status flag register bank
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module jmsf_top (
    // clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // avalon-mm slave
    input wire logic [11:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [15:0] avs_writedata_in,
    input wire logic [1:0] avs_byteenable_in,
    output logic [15:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [1:0] avs_response_out,
    // codec and fifo condition inputs
    input wire logic codec_file_out_in,
    input wire logic [15:0] fifo_count_in,
    input wire logic [15:0] fifo_size_in,
    input wire logic [1:0] fifo_trig_sel_in,
    input wire logic [31:0] enc_size_limit_in,
    input wire logic [31:0] enc_size_result_in,
    input wire logic decode_done_in,
    input wire logic decode_err_in,
    input wire logic [1:0] err_det_mode_in,
    input wire logic marker_read_in,
    input wire logic lb_overflow_in,
    input wire logic codec_irq_in,
    input wire logic op_status_read_in,
    input wire logic lb_req_pending_in,
    // mode and routing outputs
    output logic module_clk_en_out,
    output logic module_rst_out,
    output logic [2:0] data_mode_out,
    output logic bypass_out,
    output logic host_yuv_in_out,
    output logic host_yuv_out_out,
    output logic yuv420_out,
    output logic host_codec_out,
    output logic no_offset_out,
    output logic rotate_out,
    output logic irq_out
);
    import jmsf_pkg::*;

    typedef struct packed {
        jmsf_bus_e bus;
        logic [15:0] rdata;
        logic [15:0] ctrl;
        logic [15:0] ien;
        logic [11:0] flags;
        logic swrst;
        logic route_bypass;
        logic route_yin;
        logic route_yout;
        logic route_420;
        logic route_codec;
        logic irq;
    } jmsf_state_s;

    jmsf_state_s st_reg;
    jmsf_state_s st_next;

    // live fifo and encode conditions
    logic [15:0] quarter;
    logic [15:0] half;
    logic [1:0] lvl;
    logic lvl_empty;
    logic lvl_full;
    logic thr_met;
    logic size_viol;
    logic [15:0] stat_view;
    logic [15:0] wmask;
    logic [15:0] w1c;
    logic acc;
    jmsf_mode_e mode;

    // fifo level buckets, quarter and half thresholds taken from configured size
    always_comb begin
        quarter = {2'b00, fifo_size_in[15:2]};
        half = {1'b0, fifo_size_in[15:1]};
        lvl_empty = (fifo_count_in == 16'h0000);
        lvl_full = (fifo_count_in >= fifo_size_in) && !lvl_empty;
        if (fifo_count_in > half) begin
            lvl = 2'b11;
        end else if (fifo_count_in > quarter) begin
            lvl = 2'b10;
        end else if (fifo_count_in > JMSF_LVL_SMALL) begin
            lvl = 2'b01;
        end else begin
            lvl = 2'b00;
        end
        // trigger select picks which level bucket counts as met
        case (fifo_trig_sel_in)
            2'b00: thr_met = !lvl_empty;
            2'b01: thr_met = (lvl >= 2'b01);
            2'b10: thr_met = (lvl >= 2'b10);
            default: thr_met = (lvl == 2'b11);
        endcase
        size_viol = (enc_size_result_in > enc_size_limit_in);
    end

    // byte lane mask and access decode
    always_comb begin
        wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
        acc = (avs_read_in || avs_write_in) && (st_reg.bus == JMSF_BS_IDLE);
        mode = jmsf_mode_e'(st_reg.ctrl[JMSF_MODE_LSB +: 3]);
        w1c = (acc && avs_write_in && avs_address_in == JMSF_STAT_ADDR)
            ? (avs_writedata_in & wmask & JMSF_W1C_MASK) : 16'h0000;
    end

    // status view: flags masked by their enables, bit 7 fixed high
    always_comb begin
        stat_view = JMSF_STAT_FIXED;
        stat_view[JMSF_ST_FILEOUT] = codec_file_out_in;
        stat_view[JMSF_ST_LVL_LSB +: 2] = lvl;
        stat_view[11:0] = stat_view[11:0] | (st_reg.flags & st_reg.ien[11:0]);
    end

    // next state
    always_comb begin
        st_next = st_reg;
        st_next.swrst = 1'b0;
        // bus: one wait cycle then answer
        case (st_reg.bus)
            JMSF_BS_IDLE: begin
                if (acc) begin
                    st_next.bus = JMSF_BS_ACK;
                    st_next.rdata = 16'h0000;
                    if (avs_read_in && avs_address_in == JMSF_CTRL_ADDR) begin
                        st_next.rdata = st_reg.ctrl & JMSF_CTRL_WMASK;
                    end else if (avs_read_in && avs_address_in == JMSF_STAT_ADDR) begin
                        st_next.rdata = stat_view;
                    end else if (avs_read_in && avs_address_in == JMSF_IEN_ADDR) begin
                        st_next.rdata = st_reg.ien;
                    end
                    if (avs_write_in && avs_address_in == JMSF_CTRL_ADDR) begin
                        st_next.ctrl = (st_reg.ctrl & ~wmask)
                            | (avs_writedata_in & wmask & JMSF_CTRL_WMASK);
                        // write-only reset strobe, writing 0 has no effect
                        st_next.swrst = avs_writedata_in[JMSF_SWRST_BIT] && wmask[JMSF_SWRST_BIT];
                    end
                    if (avs_write_in && avs_address_in == JMSF_IEN_ADDR) begin
                        st_next.ien = (st_reg.ien & ~wmask) | (avs_writedata_in & wmask & JMSF_IEN_WMASK);
                    end
                end
            end
            JMSF_BS_ACK: st_next.bus = JMSF_BS_IDLE;
            default: st_next.bus = JMSF_BS_IDLE;
        endcase

        // write-one-clear, refused while the condition still holds; marker clears on enable low, codec on status read
        if (w1c[JMSF_ST_SIZE] && !size_viol) st_next.flags[JMSF_ST_SIZE] = 1'b0;
        if (w1c[JMSF_ST_THR] && !thr_met) st_next.flags[JMSF_ST_THR] = 1'b0;
        if (w1c[JMSF_ST_FULL] && !lvl_full) st_next.flags[JMSF_ST_FULL] = 1'b0;
        if (w1c[JMSF_ST_EMPTY] && !lvl_empty) st_next.flags[JMSF_ST_EMPTY] = 1'b0;
        if (w1c[JMSF_ST_DEC]) st_next.flags[JMSF_ST_DEC] = 1'b0;
        if (!st_next.ien[JMSF_ST_MARK]) st_next.flags[JMSF_ST_MARK] = 1'b0;
        if (op_status_read_in) st_next.flags[JMSF_ST_CODEC] = 1'b0;
        // module reset drops every sticky flag, conditions re-arm below
        if (st_reg.swrst) st_next.flags = 12'h000;

        // sets win over clears
        if (size_viol) st_next.flags[JMSF_ST_SIZE] = 1'b1;
        if (thr_met) st_next.flags[JMSF_ST_THR] = 1'b1;
        if (lvl_full) st_next.flags[JMSF_ST_FULL] = 1'b1;
        if (lvl_empty) st_next.flags[JMSF_ST_EMPTY] = 1'b1;
        if (decode_done_in && !(err_det_mode_in == JMSF_ERRDET_ON && decode_err_in)) begin
            st_next.flags[JMSF_ST_DEC] = 1'b1;
        end
        if (marker_read_in && st_next.ien[JMSF_ST_MARK]) st_next.flags[JMSF_ST_MARK] = 1'b1;
        if (lb_overflow_in) st_next.flags[JMSF_ST_LBOVF] = 1'b1;
        if (codec_irq_in) st_next.flags[JMSF_ST_CODEC] = 1'b1;
        // line buffer interrupt is a live follower, not sticky
        st_next.flags[JMSF_ST_LBINT] = lb_req_pending_in && (mode != JMSF_M_NORMAL);

        // routing decode, registered so outputs come from flops
        st_next.route_yin = 1'b0;
        st_next.route_yout = 1'b0;
        st_next.route_420 = 1'b0;
        st_next.route_codec = 1'b0;
        st_next.route_bypass = 1'b0;
        case (jmsf_mode_e'(st_next.ctrl[JMSF_MODE_LSB +: 3]))
            JMSF_M_YUV422_IN: begin
                st_next.route_yin = 1'b1;
                st_next.route_bypass = 1'b1;
            end
            JMSF_M_YUV422_OUT: begin
                st_next.route_yout = 1'b1;
                st_next.route_bypass = 1'b1;
            end
            JMSF_M_HOST_CODEC: begin
                // encode and decode both start and end at the host port
                st_next.route_codec = 1'b1;
            end
            JMSF_M_YUV420_IN: begin
                st_next.route_yin = 1'b1;
                st_next.route_420 = 1'b1;
                st_next.route_bypass = 1'b1;
            end
            JMSF_M_YUV420_OUT: begin
                st_next.route_yout = 1'b1;
                st_next.route_420 = 1'b1;
                st_next.route_bypass = 1'b1;
            end
            default: st_next.route_bypass = 1'b0;
        endcase
        st_next.irq = |(st_next.flags & st_next.ien[11:0]);
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
            st_reg.ctrl <= JMSF_CTRL_RST;
            st_reg.ien <= JMSF_IEN_RST;
        end else if (clk_en_in) begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    always_comb begin
        avs_readdata_out = st_reg.rdata;
        avs_waitrequest_out = (st_reg.bus != JMSF_BS_ACK);
        avs_response_out = 2'b00;
        module_clk_en_out = st_reg.ctrl[JMSF_EN_BIT];
        module_rst_out = st_reg.swrst;
        data_mode_out = st_reg.ctrl[JMSF_MODE_LSB +: 3];
        bypass_out = st_reg.route_bypass;
        host_yuv_in_out = st_reg.route_yin;
        host_yuv_out_out = st_reg.route_yout;
        yuv420_out = st_reg.route_420;
        host_codec_out = st_reg.route_codec;
        no_offset_out = st_reg.ctrl[JMSF_NOOFS_BIT];
        rotate_out = st_reg.ctrl[JMSF_ROT_BIT];
        irq_out = st_reg.irq;
    end

    // assertions
    property p_swrst_clears_ovf;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && st_reg.swrst && !lb_overflow_in) |=> !st_reg.flags[JMSF_ST_LBOVF];
    endproperty
    a_swrst_clears_ovf: assert property (p_swrst_clears_ovf)
        else $error("overflow flag survived module reset");

    property p_size_sets;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && size_viol) |=> st_reg.flags[JMSF_ST_SIZE];
    endproperty
    a_size_sets: assert property (p_size_sets)
        else $error("size violation flag not set");

    property p_empty_tracks;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && lvl_empty) |=> st_reg.flags[JMSF_ST_EMPTY];
    endproperty
    a_empty_tracks: assert property (p_empty_tracks)
        else $error("empty flag not set while empty");

    property p_lbint_mode;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        ($past(clk_en_in) && st_reg.flags[JMSF_ST_LBINT])
            |-> $past(lb_req_pending_in && mode != JMSF_M_NORMAL);
    endproperty
    a_lbint_mode: assert property (p_lbint_mode)
        else $error("line buffer flag without pending request");

    property p_mark_needs_en;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        st_reg.flags[JMSF_ST_MARK] |-> st_reg.ien[JMSF_ST_MARK];
    endproperty
    a_mark_needs_en: assert property (p_mark_needs_en)
        else $error("marker flag held with enable clear");

    property p_irq_or;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        irq_out == |(st_reg.flags & st_reg.ien[11:0]);
    endproperty
    a_irq_or: assert property (p_irq_or)
        else $error("interrupt not OR of enabled flags");

    property p_view_masked;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        !st_reg.ien[JMSF_ST_FULL] |-> !stat_view[JMSF_ST_FULL];
    endproperty
    a_view_masked: assert property (p_view_masked)
        else $error("masked flag visible");

    sequence s_dec_err;
        clk_en_in && decode_done_in && decode_err_in && err_det_mode_in == JMSF_ERRDET_ON
            && !st_reg.flags[JMSF_ST_DEC];
    endsequence
    property p_dec_err;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        s_dec_err |=> !st_reg.flags[JMSF_ST_DEC];
    endproperty
    a_dec_err: assert property (p_dec_err)
        else $error("decode complete set despite error");

    property p_bypass_mode;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        bypass_out |-> (st_reg.ctrl[3:1] inside {3'b001, 3'b011, 3'b101, 3'b111});
    endproperty
    a_bypass_mode: assert property (p_bypass_mode)
        else $error("bypass in wrong mode");

    // answer comes exactly one cycle after the take, whatever the enable does then
    property p_wait_one;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && acc) |=> !avs_waitrequest_out;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("bus answer not one cycle after take");

    // low enable freezes everything, so no pulse can slip into a flag
    property p_freeze;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (!clk_en_in && !sys_rst_in) |=> $stable(st_reg);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

    // reset strobe is a single cycle, a held strobe would wipe flags forever
    property p_swrst_pulse;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && module_rst_out) |=> !module_rst_out;
    endproperty
    a_swrst_pulse: assert property (p_swrst_pulse)
        else $error("module reset longer than one cycle");

    // status read clears the codec flag unless a new interrupt arrives
    property p_codec_clear;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && op_status_read_in && !codec_irq_in) |=> !st_reg.flags[JMSF_ST_CODEC];
    endproperty
    a_codec_clear: assert property (p_codec_clear)
        else $error("codec flag survived status read");

    // threshold condition sets the flag on the next edge
    property p_thr_sets;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (clk_en_in && thr_met) |=> st_reg.flags[JMSF_ST_THR];
    endproperty
    a_thr_sets: assert property (p_thr_sets)
        else $error("threshold flag not set");
endmodule : jmsf_top
`default_nettype wire
